// file: src/remote_status_cfg.svh
// remote status output encoder: offsets, bit positions, reset values
// assumes inclusion by bare name from the package; the modules do not include it
`ifndef REMOTE_STATUS_CFG_SVH
`define REMOTE_STATUS_CFG_SVH

// register offsets (byte addresses, one word each)
`define RSO_REG_STATUS 8'h00
`define RSO_REG_SELECT 8'h04
`define RSO_REG_ERROR 8'h08
`define RSO_REG_AREA 8'h0C

// default positions of the controller state flags in the status byte
`define RSO_BIT_READY 0
`define RSO_BIT_RUNNING 1
`define RSO_BIT_PAUSED 2
`define RSO_BIT_ERROR 3
`define RSO_BIT_ESTOP 4
`define RSO_BIT_GUARD 5
`define RSO_BIT_CRITICAL 6
`define RSO_BIT_WARNING 7

// field widths and positions
`define RSO_FUNC_W 6
`define RSO_ERRNUM_W 14
`define RSO_AREA_N 15
`define RSO_SEL_W 5
`define RSO_ROBOTS 16
`define RSO_STATUS_ROBOT_LSB 8
`define RSO_STATUS_FUNC_LSB 16
`define RSO_STATUS_MODE_LSB 22
`define RSO_AREA_PLANE_LSB 16

// reset values
`define RSO_SEL_RESET 5'h00
`define RSO_FUNC_RESET 6'h00
`define RSO_ERRNUM_RESET 14'h0000
`define RSO_RDATA_RESET 32'h0000_0000

`endif

// file: src/remote_status_pkg.sv
// remote status output encoder: shared types
// assumes the cfg header sits next to this file
package remote_status_pkg;
  `include "remote_status_cfg.svh"

  // how a robot-select code is read
  typedef enum logic [1:0] {
    SEL_ALL,
    SEL_ONE,
    SEL_NONE
  } sel_mode_e;

  // complete state of the encoder
  typedef struct packed {
    logic ready;
    logic running;
    logic paused;
    logic error;
    logic estop;
    logic guard;
    logic critical;
    logic warning;
    logic motors;
    logic home;
    logic power;
    logic cal;
    logic rec_req;
    logic rec_run;
    logic cmd_exec;
    logic cmd_rej;
    logic [`RSO_FUNC_W-1:0] func;
    logic accept;
    logic teach;
    logic test;
    logic [`RSO_ERRNUM_W-1:0] errnum;
    logic [`RSO_AREA_N-1:0] box;
    logic [`RSO_AREA_N-1:0] plane;
    logic [`RSO_SEL_W-1:0] sel;
    logic [31:0] rdata;
  } enc_state_s;
endpackage

// file: src/robot_select_mux.sv
// robot_select_mux: per-robot manipulator flags reduced by a select code
// assumes flag vectors are level inputs; output is combinational
`timescale 1ns/1ps
module robot_select_mux
  import remote_status_pkg::*;
#(
  parameter int ROBOTS = 16,
  parameter int SEL_W = 5
)
(
  // selection
  input wire logic [SEL_W-1:0] sel_in,
  // per-robot flags, bit n is robot n+1
  input wire logic [ROBOTS-1:0] motor_in,
  input wire logic [ROBOTS-1:0] home_in,
  input wire logic [ROBOTS-1:0] power_in,
  input wire logic [ROBOTS-1:0] cal_in,
  // reduced flags
  output logic motors_out,
  output logic home_out,
  output logic power_out,
  output logic cal_out
);

  //////////////////////////////////////////////////////////////////////////////
  // classify a select code; codes above the robot count select nothing
  function automatic sel_mode_e mode_of(input logic [SEL_W-1:0] s);
    if (s == '0)
    begin
      return SEL_ALL;
    end
    else if (int'(s) <= ROBOTS)
    begin
      return SEL_ONE;
    end
    return SEL_NONE;
  endfunction

  // flag of the one selected robot
  function automatic logic pick(input logic [ROBOTS-1:0] v, input logic [SEL_W-1:0] s);
    logic r;
    r = 1'b0;
    for (int i = 0; i < ROBOTS; i++)
    begin
      if (int'(s) == i + 1)
      begin
        r = v[i];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // all robots: any motor, every robot home, any high power, any uncalibrated
  always_comb
  begin
    motors_out = 1'b0;
    home_out = 1'b0;
    power_out = 1'b0;
    cal_out = 1'b0;
    case (mode_of(sel_in))
      SEL_ALL:
      begin
        motors_out = |motor_in;
        home_out = &home_in;
        power_out = |power_in;
        cal_out = |cal_in;
      end
      SEL_ONE:
      begin
        motors_out = pick(motor_in, sel_in);
        home_out = pick(home_in, sel_in);
        power_out = pick(power_in, sel_in);
        cal_out = pick(cal_in, sel_in);
      end
      default:
      begin
        motors_out = 1'b0;
        home_out = 1'b0;
        power_out = 1'b0;
        cal_out = 1'b0;
      end
    endcase
  end
endmodule

// file: src/remote_status_output_encoder.sv
// remote_status_output_encoder: remote status outputs of a motion controller
// assumes all inputs synchronous to sys_clk_in; outputs go to external equipment
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module remote_status_output_encoder
  import remote_status_pkg::*;
#(
  parameter int ROBOTS = `RSO_ROBOTS
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // controller state
  input wire logic startup_done_in,
  input wire logic task_running_in,
  input wire logic task_paused_in,
  input wire logic error_event_in,
  input wire logic remote_reset_in,
  input wire logic estop_in,
  input wire logic guard_in,
  input wire logic critical_event_in,
  input wire logic warning_in,
  // manipulator state, bit n is robot n+1
  input wire logic [ROBOTS-1:0] motor_in,
  input wire logic [ROBOTS-1:0] home_in,
  input wire logic [ROBOTS-1:0] power_in,
  input wire logic [ROBOTS-1:0] cal_in,
  input wire logic recover_wait_in,
  input wire logic recover_exec_in,
  // remote command state
  input wire logic cmd_busy_in,
  input wire logic cmd_refused_in,
  // function and modes
  input wire logic func_start_in,
  input wire logic [`RSO_FUNC_W-1:0] func_number_in,
  input wire logic auto_mode_in,
  input wire logic remote_device_in,
  input wire logic program_mode_in,
  input wire logic remote_io_en_in,
  input wire logic teach_in,
  input wire logic test_in,
  input wire logic [`RSO_ERRNUM_W-1:0] error_number_in,
  input wire logic [`RSO_AREA_N-1:0] box_in,
  input wire logic [`RSO_AREA_N-1:0] plane_in,
  // robot selection
  input wire logic [`RSO_SEL_W-1:0] robot_select_code_in,
  input wire logic select_apply_in,
  // controller state outputs
  output logic ready_out,
  output logic running_out,
  output logic paused_out,
  output logic error_out,
  output logic emergency_stop_active_out,
  output logic guard_open_out,
  output logic critical_fault_out,
  output logic warning_out,
  // manipulator outputs
  output logic motors_energized_out,
  output logic at_home_position_out,
  output logic high_power_mode_out,
  output logic calibration_required_out,
  output logic recovery_required_out,
  output logic recovery_in_progress_out,
  // command outputs
  output logic command_executing_out,
  output logic command_rejected_out,
  // buses and modes
  output logic [`RSO_FUNC_W-1:0] current_function_bus_out,
  output logic remote_acceptance_out,
  output logic teach_state_out,
  output logic test_state_out,
  output logic [`RSO_ERRNUM_W-1:0] error_number_bus_out,
  output logic [`RSO_AREA_N-1:0] box_area_flag_out,
  output logic [`RSO_AREA_N-1:0] plane_area_flag_out,
  output logic [`RSO_SEL_W-1:0] robot_select_code_out
);

  enc_state_s st_reg;
  enc_state_s st_next;
  logic mux_motors;
  logic mux_home;
  logic mux_power;
  logic mux_cal;

  //////////////////////////////////////////////////////////////////////////////
  // per-robot reduction runs on the applied selection, not the raw code
  robot_select_mux #(
    .ROBOTS(ROBOTS),
    .SEL_W(`RSO_SEL_W)
  ) i_robot_select_mux (
    .sel_in(st_reg.sel),
    .motor_in(motor_in),
    .home_in(home_in),
    .power_in(power_in),
    .cal_in(cal_in),
    .motors_out(mux_motors),
    .home_out(mux_home),
    .power_out(mux_power),
    .cal_out(mux_cal)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status byte in default output order
  function automatic logic [7:0] status_byte(input enc_state_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`RSO_BIT_READY] = s.ready;
    b[`RSO_BIT_RUNNING] = s.running;
    b[`RSO_BIT_PAUSED] = s.paused;
    b[`RSO_BIT_ERROR] = s.error;
    b[`RSO_BIT_ESTOP] = s.estop;
    b[`RSO_BIT_GUARD] = s.guard;
    b[`RSO_BIT_CRITICAL] = s.critical;
    b[`RSO_BIT_WARNING] = s.warning;
    return b;
  endfunction

  // read decode; unmapped offsets read zero
  function automatic logic [31:0] read_word(input enc_state_s s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == `RSO_REG_STATUS)
    begin
      w[7:0] = status_byte(s);
      w[`RSO_STATUS_ROBOT_LSB +: 8] = {s.cmd_rej, s.cmd_exec, s.rec_run, s.rec_req,
                                       s.cal, s.power, s.home, s.motors};
      w[`RSO_STATUS_FUNC_LSB +: `RSO_FUNC_W] = s.func;
      w[`RSO_STATUS_MODE_LSB +: 3] = {s.test, s.teach, s.accept};
    end
    else if (a == `RSO_REG_SELECT)
    begin
      w[`RSO_SEL_W-1:0] = s.sel;
    end
    else if (a == `RSO_REG_ERROR)
    begin
      w[`RSO_ERRNUM_W-1:0] = s.errnum;
    end
    else if (a == `RSO_REG_AREA)
    begin
      w[`RSO_AREA_N-1:0] = s.box;
      w[`RSO_AREA_PLANE_LSB +: `RSO_AREA_N] = s.plane;
    end
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state of every output; each lands one cycle after its cause, the robot flags two cycles after a selection change
  always_comb
  begin
    st_next = st_reg;
    st_next.ready = startup_done_in & ~task_running_in;
    st_next.paused = task_paused_in;
    // a paused task is not counted as running
    st_next.running = task_running_in & ~task_paused_in;
    // set wins over the remote reset arriving in the same cycle
    if (error_event_in)
    begin
      st_next.error = 1'b1;
    end
    else if (remote_reset_in)
    begin
      st_next.error = 1'b0;
    end
    st_next.estop = estop_in;
    st_next.guard = guard_in;
    // only the reset pin clears it; remote reset is deliberately ignored
    st_next.critical = st_reg.critical | critical_event_in;
    st_next.warning = warning_in;
    st_next.motors = mux_motors;
    st_next.home = mux_home;
    st_next.power = mux_power;
    st_next.cal = mux_cal;
    st_next.rec_req = recover_wait_in;
    st_next.rec_run = recover_exec_in;
    st_next.cmd_exec = cmd_busy_in;
    // rejection stays until the next command starts or a remote reset
    if (cmd_refused_in)
    begin
      st_next.cmd_rej = 1'b1;
    end
    else if (remote_reset_in || (cmd_busy_in && !st_reg.cmd_exec))
    begin
      st_next.cmd_rej = 1'b0;
    end
    // the number stays after the function ends, as the most recent one
    if (func_start_in)
    begin
      st_next.func = func_number_in;
    end
    st_next.accept = (auto_mode_in & remote_device_in)
                   | (program_mode_in & remote_io_en_in);
    st_next.teach = teach_in;
    st_next.test = test_in;
    st_next.errnum = error_number_in;
    st_next.box = box_in;
    st_next.plane = plane_in;
    // the pin wins over a register write in the same cycle
    if (select_apply_in)
    begin
      st_next.sel = robot_select_code_in;
    end
    else if (wr_in && addr_in == `RSO_REG_SELECT)
    begin
      st_next.sel = wdata_in[`RSO_SEL_W-1:0];
    end
    // read data stands only in the cycle after the strobe
    st_next.rdata = rd_in ? read_word(st_reg, addr_in) : `RSO_RDATA_RESET;
  end

  //////////////////////////////////////////////////////////////////////////////
  // all state clears under reset, so every flag shows inactive
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flip-flops
  assign ready_out = st_reg.ready;
  assign running_out = st_reg.running;
  assign paused_out = st_reg.paused;
  assign error_out = st_reg.error;
  assign emergency_stop_active_out = st_reg.estop;
  assign guard_open_out = st_reg.guard;
  assign critical_fault_out = st_reg.critical;
  assign warning_out = st_reg.warning;
  assign motors_energized_out = st_reg.motors;
  assign at_home_position_out = st_reg.home;
  assign high_power_mode_out = st_reg.power;
  assign calibration_required_out = st_reg.cal;
  assign recovery_required_out = st_reg.rec_req;
  assign recovery_in_progress_out = st_reg.rec_run;
  assign command_executing_out = st_reg.cmd_exec;
  assign command_rejected_out = st_reg.cmd_rej;
  assign current_function_bus_out = st_reg.func;
  assign remote_acceptance_out = st_reg.accept;
  assign teach_state_out = st_reg.teach;
  assign test_state_out = st_reg.test;
  assign error_number_bus_out = st_reg.errnum;
  assign box_area_flag_out = st_reg.box;
  assign plane_area_flag_out = st_reg.plane;
  assign robot_select_code_out = st_reg.sel;
  assign rdata_out = st_reg.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // checks on the outputs against their causes
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence err_raised;
    error_event_in;
  endsequence
  sequence err_quiet_hold;
    error_out && !remote_reset_in && !error_event_in;
  endsequence
  sequence crit_raised;
    critical_event_in ##1 critical_fault_out;
  endsequence
  sequence sel_applied;
    select_apply_in ##1 (robot_select_code_out == $past(robot_select_code_in));
  endsequence

  AST_READY: assert property ($past(rst_n_in)
                              |-> ready_out == $past(startup_done_in && !task_running_in))
    else $error("ready output does not follow startup and idle state");
  AST_RUN_PAUSE: assert property (!(running_out && paused_out))
    else $error("running and paused asserted together");
  AST_PAUSED: assert property (task_paused_in |=> paused_out)
    else $error("paused output missed a paused task");
  AST_ERR_SET: assert property (err_raised |=> error_out)
    else $error("error output not set after an error");
  AST_ERR_HOLD: assert property (err_quiet_hold |=> error_out)
    else $error("error output dropped without remote reset");
  AST_ERR_CLR: assert property (remote_reset_in && !error_event_in |=> !error_out)
    else $error("error output not cleared by remote reset");
  AST_ESTOP: assert property ($past(rst_n_in)
                              |-> emergency_stop_active_out == $past(estop_in))
    else $error("emergency stop output wrong");
  AST_GUARD: assert property ($past(rst_n_in) |-> guard_open_out == $past(guard_in))
    else $error("guard open output wrong");
  AST_CRIT: assert property (crit_raised |=> critical_fault_out [*8])
    else $error("critical fault cleared before reboot");
  AST_WARN: assert property ($rose(warning_in) && $stable(task_running_in)
    && $stable(task_paused_in) |=> warning_out && $stable(running_out))
    else $error("warning output late or disturbed running output");
  AST_MOTORS_ALL: assert property (robot_select_code_out == 5'h00 && motor_in != '0
                                   |=> motors_energized_out)
    else $error("motors output missed a robot with motors on");
  AST_HOME_ALL: assert property (robot_select_code_out == 5'h00 && !(&home_in)
                                 |=> !at_home_position_out)
    else $error("home output set while a robot is away");
  AST_POWER_ONE: assert property (robot_select_code_out == 5'h01
                                  |=> high_power_mode_out == $past(power_in[0]))
    else $error("high power output not from robot one");
  AST_CAL_ALL: assert property (robot_select_code_out == 5'h00 && cal_in != '0
                                |=> calibration_required_out)
    else $error("calibration output missed an uncalibrated robot");
  AST_RECOVER: assert property ($past(rst_n_in) |->
                                recovery_required_out == $past(recover_wait_in)
                                && recovery_in_progress_out == $past(recover_exec_in))
    else $error("recovery outputs wrong");
  AST_CMD_EXEC: assert property (cmd_busy_in [*2] |=> command_executing_out [*1])
    else $error("command executing output dropped during a command");
  AST_CMD_REJ: assert property (cmd_refused_in |=> command_rejected_out)
    else $error("command rejected output not set");
  AST_FUNC: assert property (func_start_in ##1 !func_start_in
                             |=> current_function_bus_out == $past(func_number_in, 2))
    else $error("function bus lost the most recent function number");
  AST_ACCEPT: assert property (auto_mode_in && remote_device_in |=> remote_acceptance_out)
    else $error("acceptance output missing in auto mode");
  AST_MODES: assert property ($past(rst_n_in) |-> teach_state_out == $past(teach_in)
                              && test_state_out == $past(test_in))
    else $error("teach or test output wrong");
  AST_ERRNUM: assert property ($past(rst_n_in)
                               |-> error_number_bus_out == $past(error_number_in))
    else $error("error number bus wrong");
  AST_AREA: assert property ($past(rst_n_in) |-> box_area_flag_out == $past(box_in)
                             && plane_area_flag_out == $past(plane_in))
    else $error("area flags wrong");
  AST_SEL_APPLY: assert property (sel_applied ##0 (!select_apply_in && !wr_in)
                                  |=> $stable(robot_select_code_out))
    else $error("robot selection not kept");
  AST_RDATA: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
    else $error("read data stands outside its cycle");
  AST_RESET: assert property ($rose(rst_n_in) |-> !error_out && !ready_out)
    else $error("outputs active straight after reset");
endmodule

// file: test/plc_select_model.sv
// external equipment side of the robot select pins
// assumes the encoder clock; settle count is shortened by the bench
`timescale 1ns/1ps
module plc_select_model #(
  parameter int SETTLE = 400000
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // bench request
  input wire logic req_in,
  input wire logic [4:0] code_in,
  // select pins
  output logic [4:0] robot_select_code_out,
  output logic select_apply_out,
  output logic done_out
);
  int cnt_reg;
  // code is held until the next request, apply only after the settle time
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 0;
      robot_select_code_out <= 5'h00;
      select_apply_out <= 1'b0;
      done_out <= 1'b0;
    end
    else if (req_in)
    begin
      robot_select_code_out <= code_in;
      cnt_reg <= SETTLE;
      done_out <= 1'b0;
    end
    else if (cnt_reg > 1)
      cnt_reg <= cnt_reg - 1;
    else if (cnt_reg == 1)
    begin
      cnt_reg <= 0;
      select_apply_out <= 1'b1;
      done_out <= 1'b1;
    end
    else
      select_apply_out <= 1'b0;
  end
endmodule

// file: test/remote_status_output_encoder_test.sv
// self-checking bench of the remote status encoder
// assumes the select model and the encoder package compiled first
`timescale 1ns/1ps
module remote_status_output_encoder_test;
  import remote_status_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in, wr_in, rd_in, req, done;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic startup_done_in, task_running_in, task_paused_in, error_event_in, remote_reset_in;
  logic estop_in, guard_in, critical_event_in, warning_in, recover_wait_in, recover_exec_in;
  logic cmd_busy_in, cmd_refused_in, func_start_in, auto_mode_in, remote_device_in;
  logic program_mode_in, remote_io_en_in, teach_in, test_in, select_apply_in;
  logic [15:0] motor_in, home_in, power_in, cal_in;
  logic [5:0] func_number_in, current_function_bus_out;
  logic [13:0] error_number_in, error_number_bus_out;
  logic [14:0] box_in, plane_in, box_area_flag_out, plane_area_flag_out;
  logic [4:0] robot_select_code_in, robot_select_code_out, code;
  logic ready_out, running_out, paused_out, error_out, emergency_stop_active_out;
  logic guard_open_out, critical_fault_out, warning_out, motors_energized_out;
  logic at_home_position_out, high_power_mode_out, calibration_required_out;
  logic recovery_required_out, recovery_in_progress_out, command_executing_out;
  logic command_rejected_out, remote_acceptance_out, teach_state_out, test_state_out;
  int num_errors = 0;
  int checks = 0;
  // level rows: startup,run,pause,estop,guard,warn,recw,rece,busy,teach,test,auto,dev,prog,io
  logic [14:0] lv_in[11] = '{15'h4000, 15'h6000, 15'h7000, 15'h0E00, 15'h01C0, 15'h0030,
    15'h000C, 15'h0008, 15'h0003, 15'h0002, 15'h0009};
  logic [11:0] lv_exp[11] = '{12'h800, 12'h400, 12'h200, 12'h1C0, 12'h038, 12'h006,
    12'h001, 12'h000, 12'h001, 12'h000, 12'h000};
  // select rows: code, {motor,home,power,cal}, {motors,home,power,cal}
  logic [4:0] sc[5] = '{5'h00, 5'h00, 5'h10, 5'h01, 5'h11};
  logic [63:0] sv[5] = '{64'h0001_FFFF_8000_0000, 64'h0000_FFFE_0000_0100,
    64'h8000_7FFF_7FFF_8000, 64'hFFFE_0001_0001_FFFE, 64'hFFFF_FFFF_FFFF_FFFF};
  logic [3:0] se[5] = '{4'hE, 4'h1, 4'h9, 4'h6, 4'h0};

  // slow clock, one encoder and the equipment model
  always #50 sys_clk_in = ~sys_clk_in;
  remote_status_output_encoder i_remote_status_output_encoder (.*);
  plc_select_model #(.SETTLE(4)) i_plc_select_model (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .code_in(code),
    .robot_select_code_out(robot_select_code_in),
    .select_apply_out(select_apply_in),
    .done_out(done)
  );

  ////////////////////////////////////////
  // shared tasks
  task automatic finish_test;
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // outputs are registered, so look one edge after the cause
  task automatic settle;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    int k;
    {rst_n_in, wr_in, rd_in, req, addr_in, wdata_in, code} = '0;
    {startup_done_in, task_running_in, task_paused_in, error_event_in, remote_reset_in} = '0;
    {critical_event_in, warning_in, recover_wait_in, recover_exec_in, cmd_busy_in} = '0;
    {cmd_refused_in, func_start_in, auto_mode_in, remote_device_in, program_mode_in} = '0;
    {remote_io_en_in, teach_in, test_in, func_number_in, error_number_in} = '0;
    {motor_in, home_in, power_in, cal_in, box_in, plane_in} = '0;
    {estop_in, guard_in} = 2'b11;
    repeat (5) @(posedge sys_clk_in);
    chk("reset", {emergency_stop_active_out, guard_open_out, rdata_out}, 32'h0);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      @(posedge sys_clk_in);
      {startup_done_in, task_running_in, task_paused_in, estop_in, guard_in, warning_in,
        recover_wait_in, recover_exec_in, cmd_busy_in, teach_in, test_in, auto_mode_in,
        remote_device_in, program_mode_in, remote_io_en_in} <= lv_in[i];
      settle;
      chk("levels", {ready_out, running_out, paused_out, emergency_stop_active_out,
        guard_open_out, warning_out, recovery_required_out, recovery_in_progress_out,
        command_executing_out, teach_state_out, test_state_out,
        remote_acceptance_out}, lv_exp[i]);
    end
    // latched events: one pulse each, then a new number without start
    @(posedge sys_clk_in);
    {error_event_in, critical_event_in, cmd_refused_in, func_start_in} <= 4'hF;
    func_number_in <= 6'h3F;
    @(posedge sys_clk_in);
    {error_event_in, critical_event_in, cmd_refused_in, func_start_in} <= 4'h0;
    func_number_in <= 6'h05;
    settle;
    chk("latched", {error_out, critical_fault_out, command_rejected_out}, 3'h7);
    chk("function", current_function_bus_out, 6'h3F);
    @(posedge sys_clk_in);
    remote_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    remote_reset_in <= 1'b0;
    settle;
    chk("remote reset", {error_out, critical_fault_out, command_rejected_out}, 3'h2);
    @(posedge sys_clk_in);
    error_number_in <= 14'h2001;
    box_in <= 15'h4001;
    plane_in <= 15'h2AAA;
    settle;
    chk("error number", error_number_bus_out, 14'h2001);
    chk("areas", {box_area_flag_out, plane_area_flag_out}, {15'h4001, 15'h2AAA});
    // robot selection through the equipment model
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk_in);
      req <= 1'b1;
      code <= sc[i];
      {motor_in, home_in, power_in, cal_in} <= sv[i];
      @(posedge sys_clk_in);
      req <= 1'b0;
      #1;
      k = 0;
      while (done !== 1'b1)
      begin
        settle;
        k++;
        if (k > 100)
        begin
          num_errors++;
          finish_test;
        end
      end
      settle;
      settle;
      chk("select", robot_select_code_out, sc[i]);
      chk("robot flags", {motors_energized_out, at_home_position_out, high_power_mode_out,
        calibration_required_out}, se[i]);
    end
    // register port, unmapped address and read data lifetime
    rd(8'h00, d);
    chk("status word", d, 32'h003F_0040);
    wr(8'h04, 32'h0000_0005);
    rd(8'h04, d);
    chk("select word", d, 32'h0000_0005);
    rd(8'h0C, d);
    chk("area word", d, 32'h2AAA_4001);
    rd(8'h08, d);
    chk("error word", d, 32'h0000_2001);
    rd(8'h10, d);
    chk("unmapped", d, 32'h0);
    settle;
    chk("rdata idle", rdata_out, 32'h0);
    // only a controller restart clears the critical fault
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    settle;
    chk("restart", {critical_fault_out, current_function_bus_out, robot_select_code_out},
      12'h0);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    settle;
    chk("after restart", critical_fault_out, 1'b0);
    finish_test;
  end
endmodule
